// file: rtl/qld_pkg.sv
// constants shared by the quick link drop supervisor and its helpers
// assumes one core clock; receive path status arrives on that clock
package qld_pkg;

  // register bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h2d;
  localparam logic [ADDR_W-1:0] THR_ADDR = 8'h2e;

  // config register layout
  localparam int FORCE_BIT = 15;
  localparam int EN_BIT    = 14;
  localparam int STS_LSB   = 8;
  localparam int SRC_LSB   = 0;
  localparam int SRC_W     = 5;

  // criterion positions inside the source and status fields
  localparam int CRIT_DESCR  = 4;
  localparam int CRIT_RXERR  = 3;
  localparam int CRIT_MLT3   = 2;
  localparam int CRIT_SNR    = 1;
  localparam int CRIT_ENERGY = 0;

  // threshold register layout
  localparam int THR_W      = 3;
  localparam int THR_LSB    = 0;
  localparam int RSV_LO_LSB = 4;
  localparam int RSV_HI_LSB = 8;

  // reset values, and the threshold loaded at strap start
  localparam logic [THR_W-1:0] THR_RST   = 3'h1;
  localparam logic [THR_W-1:0] THR_STRAP = 3'h2;
  localparam logic [THR_W-1:0] RSV_RST   = 3'h2;
  localparam logic [SRC_W-1:0] SRC_RST   = 5'h00;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  // energy detector accumulator width
  localparam int ACC_W = 8;

  // cycles after reset before the strap is trusted: three sync flops
  // plus the settled level flop, so the strap is seen one edge later
  localparam logic [2:0] SETTLE_CYC = 3'h4;

endpackage

// file: rtl/qld_crit_if.sv
// carries criterion inputs, arming and the qualified fire vector
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface qld_crit_if;
  logic [qld_pkg::SRC_W-1:0] raw;    // raw criterion levels, energy slot unused
  logic [qld_pkg::ACC_W-1:0] acc;    // energy detector accumulator
  logic [qld_pkg::THR_W-1:0] thr;    // energy loss threshold
  logic [qld_pkg::SRC_W-1:0] src_en; // per criterion enables
  logic                      armed;  // supervision active
  logic [qld_pkg::SRC_W-1:0] fire;   // enabled criteria now causing a drop

  // qualifying logic side
  modport det (input raw, acc, thr, src_en, armed, output fire);
  // register and drop side
  modport top (output raw, acc, thr, src_en, armed, input fire);
endinterface

// file: rtl/qld_sync.sv
// three flop synchroniser for a pin level, changes once flops 2 and 3 agree
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
module qld_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // pin and its settled level
  input  wire logic pin,
  output logic      level_q
);

  // chain of three; stage one is only read by stage two
  logic [2:0] chain_q;

  // capture and shift the pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chain_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      chain_q <= {chain_q[1:0], pin};
      // accept a change only when stages two and three agree
      if (chain_q[1] == chain_q[2]) begin
        level_q <= chain_q[2];
      end
    end
  end

endmodule

// file: rtl/qld_detect.sv
// qualifies each loss criterion with its enable and the arming state
// assumes all inputs on the core clock, output is combinational
`timescale 1ns/1ps
module qld_detect (
  // criterion bundle
  qld_crit_if.det crit
);

  // energy criterion from the accumulator comparison
  logic energy_low; // accumulator under threshold

  assign energy_low = crit.acc < {{(qld_pkg::ACC_W - qld_pkg::THR_W){1'b0}}, crit.thr};

  always_comb begin
    crit.fire = {qld_pkg::SRC_W{1'b0}};
    if (crit.armed) begin
      crit.fire = crit.src_en & {crit.raw[qld_pkg::SRC_W-1:1], energy_low};
    end
  end

endmodule

// file: rtl/qld_link_drop.sv
// quick link drop supervisor for the 1000BASE-T receive path
// assumes receive status on mclk, strap straight from a pin
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module qld_link_drop (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // register port
  input  wire logic [qld_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [qld_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [qld_pkg::DATA_W-1:0]  reg_rdata,
  // receive path status
  input  wire logic                        link_up,
  input  wire logic                        speed_1000,
  input  wire logic                        descr_sync_lost,
  input  wire logic                        rx_error,
  input  wire logic                        mlt3_error,
  input  wire logic                        snr_low,
  input  wire logic [qld_pkg::ACC_W-1:0]   energy_acc,
  input  wire logic                        signal_present,
  // strap pin
  input  wire logic                        quick_drop_strap,
  // controls toward the link
  output logic                             quick_link_drop,
  output logic                             tx_quiet
);

  // start-up phase: wait for the strap sync, then run
  typedef enum logic {
    ST_SETTLE,
    ST_RUN
  } qld_phase_t;

  // all state of the block
  typedef struct packed {
    logic                        force_drop;          // forced drop control
    logic                        quick_drop_enable;   // supervision enable
    logic [qld_pkg::SRC_W-1:0]   drop_source_enable;  // criterion enables
    logic [qld_pkg::SRC_W-1:0]   drop_cause_latched;  // sticky causes
    logic [qld_pkg::THR_W-1:0]   energy_loss_threshold;
    logic [qld_pkg::THR_W-1:0]   spare_hi;            // plain read/write field
    logic [qld_pkg::THR_W-1:0]   spare_lo;            // plain read/write field
    logic [qld_pkg::DATA_W-1:0]  rdata;               // read answer
    logic                        drop;                // drop request
    logic                        quiet;               // transmit squelch
    logic [2:0]                  settle_cnt;          // strap wait counter
    qld_phase_t                  phase;               // start-up phase
  } qld_state_t;

  qld_state_t s_q;   // registered state
  qld_state_t s_d;   // next state

  // helpers
  logic                        strap_level;  // settled strap
  logic                        cfg_rd;       // read of config register
  logic                        cfg_wr;       // write of config register
  logic                        thr_rd;       // read of threshold register
  logic                        thr_wr;       // write of threshold register
  logic [qld_pkg::DATA_W-1:0]  cfg_word;     // config register image
  logic [qld_pkg::DATA_W-1:0]  thr_word;     // threshold register image

  // criterion bundle between this block and the qualifier
  qld_crit_if crit ();

  // strap is a pin, so it crosses three flops
  qld_sync u_strap (
    .mclk    (mclk),
    .rst     (rst),
    .pin     (quick_drop_strap),
    .level_q (strap_level)
  );

  // enabled criteria qualified against the arming state
  qld_detect u_detect (
    .crit (crit)
  );

  // feed the qualifier
  always_comb begin
    crit.raw = {descr_sync_lost, rx_error, mlt3_error, snr_low, 1'b0};
    crit.acc = energy_acc;
    crit.thr = s_q.energy_loss_threshold;
    crit.src_en = s_q.drop_source_enable;
    // armed in gigabit with the link up
    crit.armed = s_q.quick_drop_enable & speed_1000 & link_up;
  end

  // address decode, unmapped addresses read zero and ignore writes
  assign cfg_rd = reg_rd & (reg_addr == qld_pkg::CFG_ADDR);
  assign cfg_wr = reg_wr & (reg_addr == qld_pkg::CFG_ADDR);
  assign thr_rd = reg_rd & (reg_addr == qld_pkg::THR_ADDR);
  assign thr_wr = reg_wr & (reg_addr == qld_pkg::THR_ADDR);

  always_comb begin
    cfg_word = qld_pkg::ZERO_WORD;
    cfg_word[qld_pkg::FORCE_BIT] = s_q.force_drop;
    cfg_word[qld_pkg::EN_BIT] = s_q.quick_drop_enable;
    cfg_word[qld_pkg::STS_LSB +: qld_pkg::SRC_W] = s_q.drop_cause_latched;
    cfg_word[qld_pkg::SRC_LSB +: qld_pkg::SRC_W] = s_q.drop_source_enable;
    thr_word = qld_pkg::ZERO_WORD;
    thr_word[qld_pkg::RSV_HI_LSB +: qld_pkg::THR_W] = s_q.spare_hi;
    thr_word[qld_pkg::RSV_LO_LSB +: qld_pkg::THR_W] = s_q.spare_lo;
    thr_word[qld_pkg::THR_LSB +: qld_pkg::THR_W] = s_q.energy_loss_threshold;
  end

  // next state
  always_comb begin
    s_d = s_q;

    // read data stands only in the cycle after the strobe
    s_d.rdata = qld_pkg::ZERO_WORD;
    if (cfg_rd) begin
      s_d.rdata = cfg_word;
    end else if (thr_rd) begin
      s_d.rdata = thr_word;
    end

    // software writes of the config fields
    if (cfg_wr) begin
      s_d.force_drop = reg_wdata[qld_pkg::FORCE_BIT];
      s_d.quick_drop_enable = reg_wdata[qld_pkg::EN_BIT];
      s_d.drop_source_enable = reg_wdata[qld_pkg::SRC_LSB +: qld_pkg::SRC_W];
    end

    // threshold register writes
    if (thr_wr) begin
      s_d.spare_hi = reg_wdata[qld_pkg::RSV_HI_LSB +: qld_pkg::THR_W];
      s_d.spare_lo = reg_wdata[qld_pkg::RSV_LO_LSB +: qld_pkg::THR_W];
      // software may now restore the threshold
      s_d.energy_loss_threshold = reg_wdata[qld_pkg::THR_LSB +: qld_pkg::THR_W];
    end

    // start-up: strap is trusted only once the sync chain is full
    unique case (s_q.phase)
      ST_SETTLE: begin
        s_d.settle_cnt = s_q.settle_cnt + 3'h1;
        if (s_q.settle_cnt == qld_pkg::SETTLE_CYC) begin
          s_d.phase = ST_RUN;
          if (strap_level) begin
            s_d.quick_drop_enable = 1'b1;
            s_d.energy_loss_threshold = qld_pkg::THR_STRAP;
          end
        end
      end
      ST_RUN: begin
        s_d.settle_cnt = s_q.settle_cnt;
      end
    endcase

    // read clears, a firing criterion keeps its bit
    if (cfg_rd) begin
      s_d.drop_cause_latched = {qld_pkg::SRC_W{1'b0}};
    end
    s_d.drop_cause_latched = s_d.drop_cause_latched | crit.fire;

    // drop request while any enabled criterion fires
    s_d.drop = |crit.fire;

    // squelch transmit so the partner drops the link
    s_d.quiet = s_q.force_drop & ~signal_present;
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q.force_drop <= 1'b0;
      s_q.quick_drop_enable <= 1'b0;
      s_q.drop_source_enable <= qld_pkg::SRC_RST;
      s_q.drop_cause_latched <= {qld_pkg::SRC_W{1'b0}};
      s_q.energy_loss_threshold <= qld_pkg::THR_RST;
      s_q.spare_hi <= qld_pkg::RSV_RST;
      s_q.spare_lo <= qld_pkg::RSV_RST;
      s_q.rdata <= qld_pkg::ZERO_WORD;
      s_q.drop <= 1'b0;
      s_q.quiet <= 1'b0;
      s_q.settle_cnt <= 3'h0;
      s_q.phase <= ST_SETTLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs, all from flops
  assign reg_rdata = s_q.rdata;
  assign quick_link_drop = s_q.drop;
  assign tx_quiet = s_q.quiet;

  // enable stays low during link-up is software's duty; no check here

  // forced drop quiets transmit when nothing arrives
  property p_force_quiet;
    @(posedge mclk) disable iff (rst)
    s_q.force_drop && !signal_present && !cfg_wr |=> tx_quiet;
  endproperty
  a_force_quiet: assert property (p_force_quiet) else $error("force drop did not quiet");

  // disabled supervision never drops the link
  property p_idle_no_drop;
    @(posedge mclk) disable iff (rst)
    !crit.armed |=> !quick_link_drop;
  endproperty
  a_idle_no_drop: assert property (p_idle_no_drop) else $error("drop while disarmed");

  // a config write lands in the source field next cycle
  property p_src_write;
    @(posedge mclk) disable iff (rst)
    cfg_wr |=> s_q.drop_source_enable == $past(reg_wdata[qld_pkg::SRC_W-1:0]);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source enable not written");

  // armed, enabled, firing descrambler loss latches bit and drops
  property p_descr_latch;
    @(posedge mclk) disable iff (rst)
    crit.armed && s_q.drop_source_enable[qld_pkg::CRIT_DESCR] && descr_sync_lost
      |=> s_q.drop_cause_latched[qld_pkg::CRIT_DESCR] && quick_link_drop;
  endproperty
  a_descr_latch: assert property (p_descr_latch) else $error("descrambler cause lost");

  // a disabled snr criterion never sets its bit
  property p_disabled_silent;
    @(posedge mclk) disable iff (rst)
    !s_q.drop_source_enable[qld_pkg::CRIT_SNR] && !cfg_wr
      && !s_q.drop_cause_latched[qld_pkg::CRIT_SNR]
      |=> !s_q.drop_cause_latched[qld_pkg::CRIT_SNR];
  endproperty
  a_disabled_silent: assert property (p_disabled_silent) else $error("disabled cause set");

  // a config read returns the latched causes at bits 12..8
  property p_sts_read;
    @(posedge mclk) disable iff (rst)
    cfg_rd |=> reg_rdata[qld_pkg::STS_LSB +: qld_pkg::SRC_W] == $past(s_q.drop_cause_latched);
  endproperty
  a_sts_read: assert property (p_sts_read) else $error("status field misplaced");

  // accumulator below threshold drops the link when enabled
  property p_energy_drop;
    @(posedge mclk) disable iff (rst)
    crit.armed && s_q.drop_source_enable[qld_pkg::CRIT_ENERGY]
      && ({{(qld_pkg::ACC_W - qld_pkg::THR_W){1'b0}}, s_q.energy_loss_threshold} > energy_acc)
      |=> quick_link_drop && s_q.drop_cause_latched[qld_pkg::CRIT_ENERGY];
  endproperty
  a_energy_drop: assert property (p_energy_drop) else $error("energy loss missed");

  // strap start loads threshold two and enables
  property p_strap_default;
    @(posedge mclk) disable iff (rst)
    s_q.phase == ST_SETTLE && s_q.settle_cnt == qld_pkg::SETTLE_CYC && strap_level && !thr_wr
      && !cfg_wr |=> s_q.energy_loss_threshold == qld_pkg::THR_STRAP && s_q.quick_drop_enable;
  endproperty
  a_strap_default: assert property (p_strap_default) else $error("strap default missed");

  // causes hold without a read
  property p_sts_hold;
    @(posedge mclk) disable iff (rst)
    !cfg_rd && s_q.drop_cause_latched != 5'h00 |=> (s_q.drop_cause_latched & $past(s_q.drop_cause_latched))
      == $past(s_q.drop_cause_latched);
  endproperty
  a_sts_hold: assert property (p_sts_hold) else $error("cause cleared without read");

  // a read with nothing firing empties the causes
  property p_sts_clear;
    @(posedge mclk) disable iff (rst)
    cfg_rd && crit.fire == 5'h00 |=> s_q.drop_cause_latched == 5'h00;
  endproperty
  a_sts_clear: assert property (p_sts_clear) else $error("read did not clear causes");

  // squelch lifts as soon as a signal is received again
  property p_quiet_release;
    @(posedge mclk) disable iff (rst)
    signal_present |=> !tx_quiet;
  endproperty
  a_quiet_release: assert property (p_quiet_release) else $error("quiet with signal");

  // armed, enabled receive errors latch their bit and drop
  property p_rxerr_latch;
    @(posedge mclk) disable iff (rst)
    crit.armed && s_q.drop_source_enable[qld_pkg::CRIT_RXERR] && rx_error
      |=> s_q.drop_cause_latched[qld_pkg::CRIT_RXERR] && quick_link_drop;
  endproperty
  a_rxerr_latch: assert property (p_rxerr_latch) else $error("receive error cause lost");

  // drop request falls once nothing fires
  property p_drop_release;
    @(posedge mclk) disable iff (rst)
    crit.fire == '0 |=> !quick_link_drop;
  endproperty
  a_drop_release: assert property (p_drop_release) else $error("drop without cause");

  // status field is read-only: a write leaves it alone
  property p_sts_readonly;
    @(posedge mclk) disable iff (rst)
    cfg_wr && crit.fire == '0 |=> s_q.drop_cause_latched == $past(s_q.drop_cause_latched);
  endproperty
  a_sts_readonly: assert property (p_sts_readonly) else $error("status written");

  // a threshold write after start-up lands in the energy field
  property p_thr_write;
    @(posedge mclk) disable iff (rst)
    thr_wr && s_q.phase == ST_RUN
      |=> s_q.energy_loss_threshold == $past(reg_wdata[qld_pkg::THR_LSB +: qld_pkg::THR_W]);
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold not written");

endmodule

// file: test/qld_partner.sv
// far-end link partner as seen from the receive path
// assumes the bench requests link-up and picks a prompt or slow answer
`timescale 1ns/1ps
module qld_partner (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst,
  // bench commands
  input  wire logic                       up_req,
  input  wire logic                       slow,
  input  wire logic                       silent,
  input  wire logic [qld_pkg::ACC_W-1:0]  acc_in,
  // from the device
  input  wire logic                       tx_quiet,
  // receive status toward the device
  output logic                            link_up,
  output logic                            speed_1000,
  output logic                            signal_present,
  output logic      [qld_pkg::ACC_W-1:0]  energy_acc
);
  logic [3:0] wait_q; // training cycles left before link is up

  // partner retrains from scratch whenever our transmitter goes quiet
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_q         <= 4'h1;
      link_up        <= 1'b0;
      speed_1000     <= 1'b0;
      signal_present <= 1'b0;
      energy_acc     <= 8'h00;
    end else begin
      signal_present <= !silent;
      // no signal: accumulator is meaningless, so let it wander
      energy_acc     <= silent ? ~energy_acc : acc_in;
      speed_1000     <= up_req;
      if (!up_req || tx_quiet) begin
        wait_q  <= slow ? 4'h6 : 4'h1;
        link_up <= 1'b0;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else begin
        link_up <= 1'b1;
      end
    end
  end
endmodule

// file: test/qld_link_drop_tb_top.sv
// self-checking bench: cycle model of the supervisor compared every cycle
// assumes the partner model drives the link status lines
`timescale 1ns/1ps
module qld_link_drop_tb_top;
  logic        mclk, rst, reg_wr, reg_rd, strap, up_req, slow, silent;
  logic [7:0]  reg_addr, acc_in, energy_acc, a;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [3:0]  crit;   // descrambler, rx error, mlt3, snr
  logic        link_up, speed_1000, signal_present, qdrop, tx_quiet;
  int          fail_count, cmp_count, seed, i, k;
  // model state
  logic        m_force, m_en, e_drop, e_quiet;
  logic [4:0]  m_src, m_sts, fire;
  logic [2:0]  m_thr, m_hi, m_lo;
  logic [15:0] e_rd;
  int          settle;

  qld_link_drop dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up),
    .speed_1000(speed_1000), .descr_sync_lost(crit[3]), .rx_error(crit[2]),
    .mlt3_error(crit[1]), .snr_low(crit[0]), .energy_acc(energy_acc),
    .signal_present(signal_present), .quick_drop_strap(strap),
    .quick_link_drop(qdrop), .tx_quiet(tx_quiet));

  qld_partner peer (.mclk(mclk), .rst(rst), .up_req(up_req), .slow(slow), .silent(silent),
    .acc_in(acc_in), .tx_quiet(tx_quiet), .link_up(link_up), .speed_1000(speed_1000),
    .signal_present(signal_present), .energy_acc(energy_acc));

  // reference model: reads inputs as they stood before the edge
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      {m_force, m_en, e_drop, e_quiet} = 4'h0;
      m_src = 5'h00; m_sts = 5'h00; e_rd = 16'h0000; settle = 0;
      m_thr = 3'h1; m_hi = 3'h2; m_lo = 3'h2;
    end else begin
      fire = (m_en && speed_1000 && link_up) ? m_src & {crit, energy_acc < m_thr} : 5'h00;
      e_quiet = m_force & !signal_present;
      e_drop = |fire;
      e_rd = 16'h0000;
      if (reg_rd && reg_addr == qld_pkg::CFG_ADDR) begin
        e_rd = {m_force, m_en, 1'b0, m_sts, 3'b000, m_src};
        m_sts = 5'h00;
      end
      if (reg_rd && reg_addr == qld_pkg::THR_ADDR)
        e_rd = {5'h00, m_hi, 1'b0, m_lo, 1'b0, m_thr};
      m_sts = m_sts | fire;   // a new firing beats the read clear
      if (reg_wr && reg_addr == qld_pkg::CFG_ADDR)
        {m_force, m_en, m_src} = {reg_wdata[15:14], reg_wdata[4:0]};
      if (reg_wr && reg_addr == qld_pkg::THR_ADDR)
        {m_hi, m_lo, m_thr} = {reg_wdata[10:8], reg_wdata[6:4], reg_wdata[2:0]};
      if (settle == 4 && strap) begin
        m_en = 1'b1;
        m_thr = 3'h2;
      end
      if (settle < 5) settle++;
    end
  end

  // compare one register word
  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // compare one control level
  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  // settled outputs checked mid-cycle
  always @(negedge mclk) begin
    chk_word("reg_rdata", e_rd, reg_rdata);
    chk_bit("quick_link_drop", e_drop, qdrop);
    chk_bit("tx_quiet", e_quiet, tx_quiet);
  end

  // one bus cycle; strobes stand until the next call
  task automatic op(input logic w, input logic r, input logic [7:0] ad, input logic [15:0] wd);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= ad;
    reg_wdata <= wd;
  endtask

  // bounded wait for the partner to train; idle cycles keep strobes one cycle long
  task automatic wait_link();
    for (k = 0; k < 20 && link_up !== 1'b1; k++) op(0, 0, 8'h00, 16'h0000);
    chk_bit("link_up", 1'b1, link_up);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // watchdog well beyond the expected run length
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end

  initial begin
    seed = 40;
    {rst, reg_wr, reg_rd, strap, up_req, slow, silent} = 7'b1000010;
    reg_addr = 8'h00; reg_wdata = 16'h0000; acc_in = 8'h40; crit = 4'h0;
    fail_count = 0; cmp_count = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) op(0, 0, 8'h00, 16'h0000);
    op(0, 1, qld_pkg::CFG_ADDR, 16'h0000);
    op(0, 1, qld_pkg::THR_ADDR, 16'h0000);
    op(1, 0, 8'h2f, 16'hffff);
    op(0, 1, 8'h2f, 16'h0000);
    op(1, 0, qld_pkg::CFG_ADDR, 16'h001f);
    up_req <= 1'b1;
    crit <= 4'hf;
    wait_link();
    op(0, 1, qld_pkg::CFG_ADDR, 16'h0000);
    // one source at a time against random criteria
    for (i = 0; i < 5; i++) begin
      op(1, 0, qld_pkg::CFG_ADDR, 16'h4000 | (16'h0001 << i));
      crit <= 4'($random(seed));
      acc_in <= 8'($random(seed)) & 8'h03;
      op(0, 1, qld_pkg::CFG_ADDR, 16'h0000);
      op(0, 1, qld_pkg::CFG_ADDR, 16'h0000);
    end
    slow <= 1'b0;
    // random traffic, back-to-back strobes, forced drop and silence
    for (i = 0; i < 300; i++) begin
      crit <= 4'($random(seed));
      acc_in <= 8'($random(seed)) & 8'h03;
      silent <= (($random(seed) & 7) == 0);
      a = ($random(seed) & 1) ? qld_pkg::CFG_ADDR : qld_pkg::THR_ADDR;
      if (($random(seed) & 15) == 0) a = 8'h30;
      d = 16'($random(seed));
      if (a == qld_pkg::THR_ADDR) d[2:0] = 3'h1;
      if (a == qld_pkg::CFG_ADDR && link_up !== 1'b1) d[qld_pkg::EN_BIT] = 1'b0;
      k = $random(seed) & 3;
      op(k == 0, k == 1, a, d);
    end
    // strap start
    op(0, 0, 8'h00, 16'h0000);
    strap <= 1'b1;
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) op(0, 0, 8'h00, 16'h0000);
    op(0, 1, qld_pkg::THR_ADDR, 16'h0000);
    op(0, 1, qld_pkg::CFG_ADDR, 16'h0000);
    op(1, 0, qld_pkg::THR_ADDR, 16'h0221);
    op(0, 1, qld_pkg::THR_ADDR, 16'h0000);
    op(0, 0, 8'h00, 16'h0000);
    repeat (3) @(posedge mclk);
    finish_test();
  end
endmodule
